// ==== core/txclk_regs.svh ====
// register offsets, field positions, reset values and rate constants of the tx clock block
`ifndef TXCLK_REGS_SVH
`define TXCLK_REGS_SVH
`define TXCLK_OFF_CTRL      12'h000
`define TXCLK_OFF_STAT      12'h004
`define TXCLK_OFF_PHASE     12'h008
`define TXCLK_CTRL_RATE     0
`define TXCLK_CTRL_RXSEL    1
`define TXCLK_CTRL_TXSEL_LO 2
`define TXCLK_CTRL_TXSEL_HI 3
`define TXCLK_STAT_MULT_LO  0
`define TXCLK_STAT_MULT_HI  4
`define TXCLK_STAT_ADJUST   5
`define TXCLK_STAT_INVALID  6
`define TXCLK_STAT_BYPASS   7
`define TXCLK_CTRL_RESET    4'h0
`define TXCLK_MULT_LO       5'h0a
`define TXCLK_MULT_HI       5'h14
`define TXCLK_NUM_CH        4
`endif

// ==== core/txclk_pkg.sv ====
// types shared by the tx clock rate and phase select block
package txclk_pkg;
    // three-level input clock select, as seen after level decode
    typedef enum logic [1:0] {TXSEL_REF, TXSEL_OWN, TXSEL_CHA, TXSEL_RSVD} txclk_txsel_t;
    // state of one phase tracker
    typedef struct packed {
        logic [7:0] since_ref;  // cycles since last reference rise
        logic [7:0] phase;      // captured phase offset
    } txclk_trk_t;
endpackage

// ==== core/txclk_phase_track.sv ====
// one channel's phase tracker between reference rise and selected input clock rise
module txclk_phase_track
    import txclk_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // edge events, already synchronised
    input  wire logic       ref_rise,
    input  wire logic       in_rise,
    // adjust window, high while alignment is open
    input  wire logic       adjust,
    // captured phase
    output logic [7:0]      phase
);
    txclk_trk_t s_r;  // registered state
    txclk_trk_t s_nxt;  // next state

    // count from reference rise, capture on input rise while adjusting
    always_comb begin
        s_nxt = s_r;
        if (ref_rise) begin
            s_nxt.since_ref = 8'h00;
        end else if (s_r.since_ref != 8'hff) begin
            // saturate so very slow clocks do not wrap into a bogus offset
            s_nxt.since_ref = s_r.since_ref + 8'h01;
        end
        if (adjust && in_rise) begin
            s_nxt.phase = s_r.since_ref;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign phase = s_r.phase;

    AST_PHASE_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        !adjust |=> $stable(s_r.phase))
        else $error("phase moved while locked");
endmodule // txclk_phase_track

// ==== core/txclk_top.sv ====
// tx clock rate select, rx interface clock copy and tx input clock phase alignment
// Operation
// - rate high gives serial clock twenty times reference
// - rate low gives serial clock ten times reference
// - reference rx mode, rate sets rx clock rate; here rx clocks copy the reference at the same rate in either rate setting
// - rate high: rx clocks copy half-rate reference; here they copy the full-rate reference
// - rate low: rx clocks copy full-rate reference
// - adjust phase while reset low, hold when high
// - input select picks reference, own, or channel a
// - character clock is reference, doubled when rate high
// - phase reset ignored when select and rate low
//
// The placing of the registers and the APB interface to the registers were decided locally.
`include "txclk_regs.svh"
module txclk_top
    import txclk_pkg::*;
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // clock pins from outside, sampled
    input  wire logic        ref_input_clock,
    input  wire logic        tx_input_clock_a,
    input  wire logic        tx_input_clock_b,
    input  wire logic        tx_input_clock_c,
    input  wire logic        tx_input_clock_d,
    input  wire logic        tx_phase_reset_n,
    // generated clocks and pll setting
    output logic             tx_char_clock_out,
    output logic             rx_out_clock_a,
    output logic             rx_out_clock_c,
    output logic [4:0]       tx_pll_mult
);
    localparam int NCH = `TXCLK_NUM_CH;

    typedef struct packed {
        logic        tx_pll_rate_select;     // ctrl: rate select
        logic        rx_iface_clock_select;  // ctrl: 0 = reference drives rx interface
        logic [1:0]  tx_input_clock_select;  // ctrl: input register clock source
        logic        ref_m1;                 // synchroniser stage one
        logic        ref_m2;                 // synchroniser stage two
        logic        ref_d;                  // previous synchronised level
        logic [3:0]  tck_m1;                 // input clocks, stage one
        logic [3:0]  tck_m2;                 // input clocks, stage two
        logic [3:0]  tck_d;                  // previous synchronised levels
        logic        prst_m1;                // phase reset, stage one
        logic        prst_m2;                // phase reset, stage two
        logic        adjust;                 // alignment window open
        logic [7:0]  hp_cnt;                 // cycles in current reference half period
        logic [7:0]  hp_len;                 // last measured half period
        logic [7:0]  dbl_cnt;                // high time left in doubled clock
        logic        char_clk;               // character clock
        logic        rxa;                    // rx clock a
        logic        rxc;                    // rx clock c
        logic [4:0]  mult;                   // pll multiplier
        logic [31:0] rdata;                  // apb read data
        logic        rdy;                    // apb ready
        logic        err;                    // apb error
    } txclk_st_t;

    txclk_st_t  s_r;                  // registered state
    txclk_st_t  s_nxt;                // next state
    logic       ref_rise;             // reference rising edge pulse
    logic       ref_edge;             // either reference edge
    logic [3:0] tck_rise;             // input clock rising edge pulses
    logic [3:0] sel_rise;             // selected clock rise per channel
    logic [7:0] phase [NCH];          // captured phases
    logic       bypass;               // phase-align buffer bypassed
    logic       invalid;              // half-rate with input clocks selected

    // apb address match, used by the error path only; reads decode paddr directly
    function automatic logic hit(input logic [11:0] a);
        hit = (a == `TXCLK_OFF_CTRL) || (a == `TXCLK_OFF_STAT) || (a == `TXCLK_OFF_PHASE);
    endfunction

    // edges from second synchroniser stage only
    assign ref_rise = s_r.ref_m2 & ~s_r.ref_d;
    assign ref_edge = s_r.ref_m2 ^ s_r.ref_d;
    assign tck_rise = s_r.tck_m2 & ~s_r.tck_d;
    // no aligner when reference clocks the input register at full rate
    assign bypass   = (s_r.tx_input_clock_select == TXSEL_REF) && !s_r.tx_pll_rate_select;
    // flagged only; the host is expected never to set this up
    assign invalid  = (s_r.tx_input_clock_select != TXSEL_REF) && s_r.tx_pll_rate_select;

    // per-channel clock choice and tracker
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_comb begin
                case (txclk_txsel_t'(s_r.tx_input_clock_select))
                    TXSEL_REF: sel_rise[g] = ref_rise;
                    TXSEL_OWN: sel_rise[g] = tck_rise[g];
                    TXSEL_CHA: sel_rise[g] = tck_rise[0];
                    default:   sel_rise[g] = ref_rise;        // reserved code acts as low
                endcase
            end
            txclk_phase_track u_trk (
                .pclk     (pclk),
                .presetn  (presetn),
                .ref_rise (ref_rise),
                .in_rise  (sel_rise[g]),
                .adjust   (s_r.adjust),
                .phase    (phase[g])
            );
        end
    endgenerate

    // next-state logic: synchronisers, clocks, alignment, apb
    always_comb begin
        s_nxt = s_r;
        // two-stage synchronisers
        s_nxt.ref_m1  = ref_input_clock;
        s_nxt.ref_m2  = s_r.ref_m1;
        s_nxt.ref_d   = s_r.ref_m2;
        s_nxt.tck_m1  = {tx_input_clock_d, tx_input_clock_c, tx_input_clock_b, tx_input_clock_a};
        s_nxt.tck_m2  = s_r.tck_m1;
        s_nxt.tck_d   = s_r.tck_m2;
        s_nxt.prst_m1 = tx_phase_reset_n;
        s_nxt.prst_m2 = s_r.prst_m1;
        // pll multiplier
        s_nxt.mult = s_r.tx_pll_rate_select ? `TXCLK_MULT_HI : `TXCLK_MULT_LO;
        // phase reset sampled on reference rise
        if (bypass) begin
            s_nxt.adjust = 1'b0;
        end else if (ref_rise) begin
            s_nxt.adjust = !s_r.prst_m2;
        end
        // reference half-period measure for the doubled clock
        if (ref_edge) begin
            s_nxt.hp_cnt = 8'h01;
            s_nxt.hp_len = s_r.hp_cnt;
        end else if (s_r.hp_cnt != 8'hff) begin
            s_nxt.hp_cnt = s_r.hp_cnt + 8'h01;
        end
        // character clock: copy at low rate, one pulse per reference edge at high rate
        if (!s_r.tx_pll_rate_select) begin
            s_nxt.char_clk = s_r.ref_m2;
            s_nxt.dbl_cnt  = 8'h00;
        end else if (ref_edge) begin
            // high for half a half-period; duty is only as good as the sampling grid
            s_nxt.dbl_cnt  = (s_r.hp_len > 8'h03) ? {1'b0, s_r.hp_len[7:1]} : 8'h01;
            s_nxt.char_clk = 1'b1;
        end else if (s_r.dbl_cnt > 8'h01) begin
            s_nxt.dbl_cnt  = s_r.dbl_cnt - 8'h01;
        end else begin
            s_nxt.dbl_cnt  = 8'h00;
            s_nxt.char_clk = 1'b0;
        end
        // rx clocks copy reference in either rate; otherwise recovered clocks live elsewhere
        if (!s_r.rx_iface_clock_select) begin
            s_nxt.rxa = s_r.ref_m2;
            s_nxt.rxc = s_r.ref_m2;
        end else begin
            s_nxt.rxa = 1'b0;
            s_nxt.rxc = 1'b0;
        end
        // apb: answer ready in the access cycle, zero wait states
        s_nxt.rdy = psel && !penable;
        s_nxt.err = psel && !penable && !hit(paddr);
        s_nxt.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (paddr == `TXCLK_OFF_CTRL) begin
                s_nxt.rdata[`TXCLK_CTRL_RATE]  = s_r.tx_pll_rate_select;
                s_nxt.rdata[`TXCLK_CTRL_RXSEL] = s_r.rx_iface_clock_select;
                s_nxt.rdata[`TXCLK_CTRL_TXSEL_HI:`TXCLK_CTRL_TXSEL_LO] =
                    s_r.tx_input_clock_select;
            end else if (paddr == `TXCLK_OFF_STAT) begin
                s_nxt.rdata[`TXCLK_STAT_MULT_HI:`TXCLK_STAT_MULT_LO] = s_r.mult;
                s_nxt.rdata[`TXCLK_STAT_ADJUST]  = s_r.adjust;
                s_nxt.rdata[`TXCLK_STAT_INVALID] = invalid;
                s_nxt.rdata[`TXCLK_STAT_BYPASS]  = bypass;
            end else if (paddr == `TXCLK_OFF_PHASE) begin
                s_nxt.rdata = {phase[3], phase[2], phase[1], phase[0]};
            end
        end
        // write at the completing access edge
        if (psel && penable && pwrite && s_r.rdy && (paddr == `TXCLK_OFF_CTRL)) begin
            s_nxt.tx_pll_rate_select    = pwdata[`TXCLK_CTRL_RATE];
            s_nxt.rx_iface_clock_select = pwdata[`TXCLK_CTRL_RXSEL];
            s_nxt.tx_input_clock_select = pwdata[`TXCLK_CTRL_TXSEL_HI:`TXCLK_CTRL_TXSEL_LO];
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.mult <= `TXCLK_MULT_LO;
            // phase reset pin idles high; a low reset value would fake a request
            s_r.prst_m1 <= 1'b1;
            s_r.prst_m2 <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign prdata            = s_r.rdata;
    assign pready            = s_r.rdy;
    assign pslverr           = s_r.err;
    assign tx_char_clock_out = s_r.char_clk;
    assign rx_out_clock_a    = s_r.rxa;
    assign rx_out_clock_c    = s_r.rxc;
    assign tx_pll_mult       = s_r.mult;

    AST_MULT_HI: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.tx_pll_rate_select |=> (tx_pll_mult == `TXCLK_MULT_HI))
        else $error("multiplier not twenty");
    AST_MULT_LO: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.tx_pll_rate_select |=> (tx_pll_mult == `TXCLK_MULT_LO))
        else $error("multiplier not ten");
    AST_RX_COPY: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.rx_iface_clock_select |=> (rx_out_clock_a == $past(s_r.ref_m2, 1))
            && (rx_out_clock_c == rx_out_clock_a))
        else $error("rx clocks do not follow reference");
    AST_RX_HALF: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_r.rx_iface_clock_select && s_r.tx_pll_rate_select && ref_edge)
            |=> (rx_out_clock_a == s_r.ref_d) && (rx_out_clock_c == s_r.ref_d))
        else $error("half-rate rx clock mismatch");
    AST_RX_FULLRATE: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_r.rx_iface_clock_select && !s_r.tx_pll_rate_select && ref_edge)
            |=> (rx_out_clock_a == s_r.ref_d) && (rx_out_clock_c == s_r.ref_d))
        else $error("full-rate rx clock mismatch");
    AST_RX_FULL: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.rx_iface_clock_select |=> !rx_out_clock_a && !rx_out_clock_c)
        else $error("rx clocks driven outside reference mode");
    AST_ADJ_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
        (ref_rise && !s_r.prst_m2 && !bypass) |=> s_r.adjust)
        else $error("alignment not opened");
    AST_ADJ_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (ref_rise && s_r.prst_m2) ##1 !ref_rise [*2] |-> !s_r.adjust)
        else $error("alignment not locked");
    AST_SEL_CHA: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.tx_input_clock_select == TXSEL_CHA) |-> (sel_rise[1] == tck_rise[0])
            && (sel_rise[3] == tck_rise[0]))
        else $error("channel a clock not shared");
    AST_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
        bypass |=> !s_r.adjust)
        else $error("phase reset honoured in bypass");
    AST_CHAR_LO: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.tx_pll_rate_select |=> (tx_char_clock_out == $past(s_r.ref_m2, 1)))
        else $error("character clock not reference copy");
    AST_CHAR_DBL: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.tx_pll_rate_select && ref_edge) |=> tx_char_clock_out)
        else $error("doubled character clock missed an edge");
    AST_APB_RDY: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb ready not one access cycle");
endmodule // txclk_top

// ==== verification/txclk_host_model.sv ====
// host side model: reference clock, four coherent input clocks and the phase reset pin
module txclk_host_model #(
    // phase offsets of the input clocks in pclk cycles
    parameter logic [3:0] OFF_A = 4'h2,
    parameter logic [3:0] OFF_B = 4'h4,
    parameter logic [3:0] OFF_C = 4'h6,
    parameter logic [3:0] OFF_D = 4'h9
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // alignment request from the bench
    input  wire logic align_go,
    // clock pins toward the device
    output logic      ref_input_clock,
    output logic      tx_input_clock_a,
    output logic      tx_input_clock_b,
    output logic      tx_input_clock_c,
    output logic      tx_input_clock_d,
    output logic      tx_phase_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ph_r;   // position in the 16-cycle reference period
    logic [1:0] left_r; // reference rises still to hold the reset low
    // one shared period keeps every input clock frequency coherent
    assign ref_input_clock  = (ph_r < 4'h8);
    assign tx_input_clock_a = (4'(ph_r - OFF_A) < 4'h8);
    assign tx_input_clock_b = (4'(ph_r - OFF_B) < 4'h8);
    assign tx_input_clock_c = (4'(ph_r - OFF_C) < 4'h8);
    assign tx_input_clock_d = (4'(ph_r - OFF_D) < 4'h8);
    // reset held over three reference rises, one spare for the sampler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r             <= 4'h0;
            left_r           <= 2'h0;
            tx_phase_reset_n <= 1'b1; // pulled up while idle
        end else begin
            ph_r <= ph_r + 4'h1;
            if (align_go) begin
                tx_phase_reset_n <= 1'b0;
                left_r           <= 2'h3;
            end else if (ph_r == 4'hf && left_r != 2'h0) begin
                left_r           <= left_r - 2'h1;
                tx_phase_reset_n <= (left_r == 2'h1);
            end
        end
    end
endmodule // txclk_host_model

// ==== verification/testbench.sv ====
// self-checking bench for the tx clock rate and phase select block
`include "txclk_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0;     // clock and reset
    logic        psel = 1'b0, penable = 1'b0;     // apb request
    logic        pwrite = 1'b0, align_go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;      // rd: last read word
    logic        pready, pslverr, ref_clk, ca, cb, cc, cd, prst_n, chr, rxa, rxc;
    logic [4:0]  mult;
    logic [15:0] lfsr = 16'h539d;                 // random source
    logic [64:0] exp_q[$], e;                     // {error, mask, data}
    logic [3:0]  prev, cur;                       // clock levels: ref, char, rx a, rx c
    int          cnt[5];                          // rises per clock, rx a high time
    int          error_cnt = 0;
    int          samples_checked = 0;
    always #2 pclk = ~pclk;
    txclk_top u_txclk_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_input_clock(ref_clk), .tx_input_clock_a(ca),
        .tx_input_clock_b(cb), .tx_input_clock_c(cc), .tx_input_clock_d(cd),
        .tx_phase_reset_n(prst_n), .tx_char_clock_out(chr), .rx_out_clock_a(rxa),
        .rx_out_clock_c(rxc), .tx_pll_mult(mult));
    txclk_host_model u_txclk_host_model(.pclk(pclk), .presetn(presetn), .align_go(align_go),
        .ref_input_clock(ref_clk), .tx_input_clock_a(ca), .tx_input_clock_b(cb),
        .tx_input_clock_c(cc), .tx_input_clock_d(cd), .tx_phase_reset_n(prst_n));
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        samples_checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one apb transfer; the note goes on the queue before the request starts
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic [31:0] m, input logic er);
        exp_q.push_back({er, m, ex});
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the rising edge at which ready is seen high, take the data there
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // monitor: sampled mid-cycle, where registered answers have settled
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check({pslverr, prdata & e[63:32]}, {e[64], e[31:0] & e[63:32]});
        end
    end
    // settle, then count edges over twenty reference periods
    task automatic clocks(input int ec, input int er, input int eh);
        repeat (40) @(posedge pclk);
        cnt  = '{default: 0};
        prev = {ref_clk, chr, rxa, rxc};
        repeat (320) begin
            @(negedge pclk);
            cur = {ref_clk, chr, rxa, rxc};
            for (int i = 0; i < 4; i++) cnt[i] += int'(cur[i] & !prev[i]);
            cnt[4] += int'(rxa);
            prev = cur;
        end
        check(33'(cnt[3]), 33'd20);
        check(33'(cnt[2]), 33'(ec));
        check(33'(cnt[1]), 33'(er));
        check(33'(cnt[0]), 33'(er));
        check(33'(cnt[4]), 33'(eh));
    endtask
    task automatic pulse();
        @(posedge pclk);
        align_go <= 1'b1;
        @(posedge pclk);
        align_go <= 1'b0;
    endtask
    // channel phases relative to channel a
    task automatic diffs(input logic [7:0] db, input logic [7:0] dc, input logic [7:0] dd);
        apb(1'b0, `TXCLK_OFF_PHASE, 32'h0, 32'h0, 32'h0, 1'b0);
        check(33'(8'(rd[15:8] - rd[7:0])), 33'(db));
        check(33'(8'(rd[23:16] - rd[7:0])), 33'(dc));
        check(33'(8'(rd[31:24] - rd[7:0])), 33'(dd));
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check(33'(mult), 33'(`TXCLK_MULT_LO));
        apb(1'b0, `TXCLK_OFF_CTRL, 32'h0, 32'h0, 32'hffffffff, 1'b0);
        apb(1'b0, `TXCLK_OFF_STAT, 32'h0, 32'h8a, 32'hff, 1'b0);
        apb(1'b0, 12'h00c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        lfsr = lfsr_next(lfsr);
        apb(1'b1, `TXCLK_OFF_STAT, {lfsr, lfsr}, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `TXCLK_OFF_STAT, 32'h0, 32'h8a, 32'hff, 1'b0);
        clocks(20, 20, 160);
        lfsr = lfsr_next(lfsr);
        apb(1'b1, `TXCLK_OFF_CTRL, {lfsr, 16'h0001}, 32'h0, 32'h0, 1'b0);
        apb(1'b0, `TXCLK_OFF_CTRL, 32'h0, 32'h1, 32'hffffffff, 1'b0);
        check(33'(mult), 33'(`TXCLK_MULT_HI));
        apb(1'b0, `TXCLK_OFF_STAT, 32'h0, 32'h14, 32'hdf, 1'b0);
        clocks(40, 20, 160);
        apb(1'b1, `TXCLK_OFF_CTRL, 32'h3, 32'h0, 32'h0, 1'b0);
        clocks(40, 0, 0);
        apb(1'b1, `TXCLK_OFF_CTRL, 32'h4, 32'h0, 32'h0, 1'b0);
        clocks(20, 20, 160);
        pulse();
        repeat (32) @(posedge pclk);
        apb(1'b0, `TXCLK_OFF_STAT, 32'h0, 32'h20, 32'h20, 1'b0);
        repeat (100) @(posedge pclk);
        apb(1'b0, `TXCLK_OFF_STAT, 32'h0, 32'h0, 32'h20, 1'b0);
        diffs(8'h02, 8'h04, 8'h07);
        apb(1'b1, `TXCLK_OFF_CTRL, 32'h8, 32'h0, 32'h0, 1'b0);
        repeat (40) @(posedge pclk);
        diffs(8'h02, 8'h04, 8'h07);
        pulse();
        repeat (100) @(posedge pclk);
        diffs(8'h00, 8'h00, 8'h00);
        apb(1'b1, `TXCLK_OFF_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
        pulse();
        repeat (32) @(posedge pclk);
        apb(1'b0, `TXCLK_OFF_STAT, 32'h0, 32'h8a, 32'hff, 1'b0);
        end_of_test();
    end
    // watchdog: the whole run needs about 1800 cycles
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
endmodule // testbench
